// ==== hdl/cei_consts.vh ====
// constants for the comparator edge interrupt and input select block
// assumes an AXI4-Lite slave with 32-bit data and word-aligned registers
`ifndef CEI_CONSTS_VH
`define CEI_CONSTS_VH
`define CEI_ADDR_W 4
`define CEI_OFF_CTRL 4'h0
`define CEI_OFF_STATUS 4'h4
`define CEI_OFF_MASK 4'h8
`define CEI_OFF_RESULT 4'hc
`define CEI_CTRL_RESET 8'h00
`define CEI_CTRL_WMASK 8'hf3
`define CEI_BIT_RISE 7
`define CEI_BIT_FALL 6
`define CEI_PSEL_HI 5
`define CEI_PSEL_LO 4
`define CEI_NSEL_HI 1
`define CEI_NSEL_LO 0
`define CEI_PSEL_PIN 2'h0
`define CEI_PSEL_DAC 2'h1
`define CEI_PSEL_FVR 2'h2
`define CEI_PSEL_GND 2'h3
`define CEI_RESP_OKAY 2'h0
`define CEI_RESP_SLVERR 2'h2
`endif

// ==== hdl/cei_edge_detect.v ====
// edge detector on the comparator result
// assumes comparator_result is synchronous to aclk
`timescale 1ns/1ns
module cei_edge_detect (
	input wire aclk,
	input wire aresetn,
	input wire level_in,
	output reg rise,
	output reg fall
);
reg last;
always @(posedge aclk) begin
	if (!aresetn) begin
		last <= 1'b0;
		rise <= 1'b0;
		fall <= 1'b0;
	end else begin
		last <= level_in;
		rise <= level_in & ~last;
		fall <= ~level_in & last;
	end
end
endmodule // cei_edge_detect

// ==== hdl/cei_comparator_ctrl.v ====
// comparator control register, edge interrupt flag and input routing
// assumes an AXI4-Lite master on aclk and a synchronous comparator result
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`include "cei_consts.vh"
module cei_comparator_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire [`CEI_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`CEI_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire comparator_result,
	output reg comparator_irq_flag,
	output reg irq,
	output reg plus_sel_pin,
	output reg plus_sel_dac,
	output reg plus_sel_fvr,
	output reg plus_sel_gnd,
	output reg [3:0] minus_sel_onehot
);
////////////////////////////////////////////////////////////////////////////
reg [7:0] ctrl;
reg [`CEI_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg aw_held;
reg w_held;
reg [`CEI_ADDR_W-1:0] ar_addr;
reg ar_held;
reg status;
reg mask;
reg result_sync;
wire rise;
wire fall;
wire do_write;
wire flag_event;
wire clear_flag;
reg [7:0] next_ctrl;
reg next_status;
reg next_mask;

// decode of a 2-bit select into four one-hot lines
function [3:0] cei_dec2;
	input [1:0] code;
	begin
		cei_dec2 = 4'h1 << code;
	end
endfunction

cei_edge_detect u_edge (
	.aclk(aclk),
	.aresetn(aresetn),
	.level_in(comparator_result),
	.rise(rise),
	.fall(fall)
);

////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order
assign do_write = aw_held & w_held & ~s_axi_bvalid;

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 4'h0;
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CEI_RESP_OKAY;
	end else begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		if (s_axi_awvalid & ~aw_held & ~s_axi_awready) begin
			s_axi_awready <= 1'b1;
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid & ~w_held & ~s_axi_wready) begin
			s_axi_wready <= 1'b1;
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			case (aw_addr)
				`CEI_OFF_CTRL, `CEI_OFF_STATUS, `CEI_OFF_MASK,
				`CEI_OFF_RESULT: s_axi_bresp <= `CEI_RESP_OKAY;
				default: s_axi_bresp <= `CEI_RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// register updates; a flag event outranks a write-one clear
assign clear_flag = do_write & (aw_addr == `CEI_OFF_STATUS) & w_strb[0] &
	w_data[0];
assign flag_event = (fall & ctrl[`CEI_BIT_FALL]) |
	(rise & ctrl[`CEI_BIT_RISE]);

always @* begin
	next_ctrl = ctrl;
	next_mask = mask;
	next_status = status;
	if (do_write & w_strb[0]) begin
		if (aw_addr == `CEI_OFF_CTRL)
			next_ctrl = w_data[7:0] & `CEI_CTRL_WMASK;
		if (aw_addr == `CEI_OFF_MASK)
			next_mask = w_data[0];
	end
	if (clear_flag)
		next_status = 1'b0;
	if (flag_event)
		next_status = 1'b1;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		ctrl <= `CEI_CTRL_RESET;
		status <= 1'b0;
		mask <= 1'b0;
	end else begin
		ctrl <= next_ctrl;
		status <= next_status;
		mask <= next_mask;
	end
end

////////////////////////////////////////////////////////////////////////////
// read channel
always @(posedge aclk) begin
	if (!aresetn) begin
		ar_held <= 1'b0;
		ar_addr <= 4'h0;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `CEI_RESP_OKAY;
		result_sync <= 1'b0;
	end else begin
		result_sync <= comparator_result;
		s_axi_arready <= 1'b0;
		if (s_axi_arvalid & ~ar_held & ~s_axi_arready & ~s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
			ar_held <= 1'b1;
			ar_addr <= s_axi_araddr;
		end
		if (ar_held & ~s_axi_rvalid) begin
			ar_held <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `CEI_RESP_OKAY;
			case (ar_addr)
				`CEI_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl};
				`CEI_OFF_STATUS: s_axi_rdata <= {31'h0, status};
				`CEI_OFF_MASK: s_axi_rdata <= {31'h0, mask};
				`CEI_OFF_RESULT: s_axi_rdata <= {31'h0, result_sync};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `CEI_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// routing outputs, registered so they follow ctrl by one cycle
always @(posedge aclk) begin
	if (!aresetn) begin
		comparator_irq_flag <= 1'b0;
		irq <= 1'b0;
		plus_sel_pin <= 1'b1;
		plus_sel_dac <= 1'b0;
		plus_sel_fvr <= 1'b0;
		plus_sel_gnd <= 1'b0;
		minus_sel_onehot <= 4'h1;
	end else begin
		comparator_irq_flag <= next_status;
		irq <= next_status & next_mask;
		plus_sel_pin <= (ctrl[5:4] == `CEI_PSEL_PIN);
		plus_sel_dac <= (ctrl[5:4] == `CEI_PSEL_DAC);
		plus_sel_fvr <= (ctrl[5:4] == `CEI_PSEL_FVR);
		plus_sel_gnd <= (ctrl[5:4] == `CEI_PSEL_GND);
		minus_sel_onehot <= cei_dec2(ctrl[`CEI_NSEL_HI:`CEI_NSEL_LO]);
	end
end
endmodule // cei_comparator_ctrl

// ==== tb/cei_ctrl_monitor.sv ====
// port checker for the comparator control block
// assumes a bind onto cei_comparator_ctrl
`timescale 1ns/1ns
module cei_ctrl_monitor (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_wvalid,
	input wire comparator_result,
	input wire comparator_irq_flag,
	input wire irq,
	input wire plus_sel_pin,
	input wire plus_sel_dac,
	input wire plus_sel_fvr,
	input wire plus_sel_gnd,
	input wire [3:0] minus_sel_onehot
);
	reg [3:0] wv;
	wire [3:0] ps;
	assign ps = {plus_sel_gnd, plus_sel_fvr, plus_sel_dac, plus_sel_pin};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// recent write beats; the selects may only move, and the flag only fall, behind one
	always @(posedge aclk) wv <= {wv[2:0], s_axi_wvalid};
	////////////////////////////////////////
	a_plus_onehot: assert property ($onehot(ps))
		else $error("plus select");
	a_minus_onehot: assert property ($onehot(minus_sel_onehot))
		else $error("minus select");
	a_plus_held: assert property (wv == 4'h0 |-> $stable(ps))
		else $error("plus moved");
	a_minus_held: assert property (wv == 4'h0 |->
		$stable(minus_sel_onehot))
		else $error("minus moved");
	// edge pulse is one cycle behind the pin, the flag one more
	a_flag_cause: assert property ($rose(comparator_irq_flag) |->
		$past(comparator_result, 2) != $past(comparator_result, 3))
		else $error("flag without edge");
	a_flag_sticky: assert property ($fell(comparator_irq_flag) |->
		wv != 4'h0)
		else $error("flag lost");
	a_irq_flag: assert property (irq |-> comparator_irq_flag)
		else $error("irq without flag");
	cover property ($rose(comparator_irq_flag));
	cover property ($fell(comparator_irq_flag));
	cover property ($rose(irq));
endmodule // cei_ctrl_monitor

// ==== tb/test_cei_comparator_ctrl.sv ====
// bench for the comparator control block
// assumes the hdl folder on the include path
`timescale 1ns/1ns
`include "cei_consts.vh"
module test_cei_comparator_ctrl;
	reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	reg s_axi_arvalid = 0, comparator_result = 0;
	// responses always accepted: the bench never stalls them
	reg s_axi_bready = 1, s_axi_rready = 1;
	reg [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	reg [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	reg [31:0] s_axi_wdata = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, comparator_irq_flag, irq;
	wire plus_sel_pin, plus_sel_dac, plus_sel_fvr, plus_sel_gnd;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] minus_sel_onehot;
	int fail_count = 0, num_checks = 0, cyc = 0, m;
	always #25 aclk = ~aclk;
	cei_comparator_ctrl i_dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.comparator_result(comparator_result),
		.comparator_irq_flag(comparator_irq_flag),
		.irq(irq),
		.plus_sel_pin(plus_sel_pin),
		.plus_sel_dac(plus_sel_dac),
		.plus_sel_fvr(plus_sel_fvr),
		.plus_sel_gnd(plus_sel_gnd),
		.minus_sel_onehot(minus_sel_onehot)
	);
	always @(posedge aclk) if (++cyc == 3000) begin
		fail_count++;
		stop_test;
	end
	////////////////////////////////////////
	task chk(input [31:0] s, input [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input [3:0] a, input [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'h1);
		// only the four aligned words are registers
		chk(s_axi_bresp, (a[1:0] == 2'h0) ? `CEI_RESP_OKAY :
			`CEI_RESP_SLVERR);
	endtask
	task rd(input [3:0] a, input [31:0] e, input [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'h1);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, r);
	endtask
	task hit(input v, input e);
		comparator_result <= v;
		repeat (5) @(posedge aclk);
		chk(comparator_irq_flag, e);
		wr(4'h4, 1);
	endtask
	////////////////////////////////////////
	task t_sel;
		rd(4'h0, 0, 0);
		for (m = 0; m < 4; m++) begin
			// reserved bits 3:2 written high, must read back low
			wr(4'h0, 32'hc | m * 17);
			rd(4'h0, m * 17, 0);
			chk({plus_sel_gnd, plus_sel_fvr, plus_sel_dac, plus_sel_pin},
				1 << m);
			chk(minus_sel_onehot, 1 << m);
		end
		// low byte lane off: the write must leave ctrl alone
		s_axi_wstrb <= 4'he;
		wr(4'h0, 32'h000000c0);
		s_axi_wstrb <= 4'hf;
		rd(4'h0, 32'h33, 0);
		wr(4'h6, 32'h000000ff);
		rd(4'h6, 0, `CEI_RESP_SLVERR);
	endtask
	task t_edge;
		for (m = 0; m < 4; m++) begin
			wr(4'h0, m << 6);
			hit(1, m[1]);
			hit(0, m[0]);
		end
	endtask
	task t_irq;
		wr(4'h8, 1);
		comparator_result <= 1;
		repeat (5) @(posedge aclk);
		chk(irq, 1);
		rd(4'hc, 1, 0);
		rd(4'h4, 1, 0);
		rd(4'h8, 1, 0);
		wr(4'h8, 0);
		repeat (2) @(posedge aclk);
		chk(irq, 0);
		wr(4'h4, 1);
		chk(comparator_irq_flag, 0);
		hit(0, 1);
		repeat (3) @(posedge aclk);
		chk(comparator_irq_flag, 0);
	endtask
	task stop_test;
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_sel;
		t_edge;
		t_irq;
		stop_test;
	end
endmodule // test_cei_comparator_ctrl
bind cei_comparator_ctrl cei_ctrl_monitor i_mon (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_wvalid(s_axi_wvalid),
	.comparator_result(comparator_result),
	.comparator_irq_flag(comparator_irq_flag),
	.irq(irq),
	.plus_sel_pin(plus_sel_pin),
	.plus_sel_dac(plus_sel_dac),
	.plus_sel_fvr(plus_sel_fvr),
	.plus_sel_gnd(plus_sel_gnd),
	.minus_sel_onehot(minus_sel_onehot)
);
